//--- csh_dev.sv
// device end: transmit cell buffer, multicast bitmap, main setup word one
// assumes the controller issues one byte request at a time and waits for ack
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "csh_map.svh"
module csh_dev #(
	parameter int EXT_LAT = `CSH_EXT_LAT
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// byte register bus
	csh_upbus_if.dev bus,
	// transmit engine read port
	input wire logic [5:0] tx_rd_idx,
	output logic [7:0] tx_rd_byte,
	// multicast lookup
	input wire logic mc_valid,
	input wire logic mc_is_ctrl,
	input wire logic [7:0] mc_net,
	output logic to_phy0_queue,
	output logic to_ctrl_rx,
	// UTOPIA transmit pin control
	input wire logic utx_active,
	input wire logic shared_bus,
	input wire logic slave_role,
	output logic utx_soc_oe,
	output logic utx_data_oe,
	// lookup SRAM selects
	input wire logic lut_req,
	input wire logic lut_bank,
	output logic lookup_sram_select_zero,
	output logic lookup_sram_select_one,
	// configuration view
	output logic transmit_float_control,
	output logic sdram_enable,
	output logic queue0_only,
	output logic atm_layer_mode,
	output logic two_srams,
	output logic cell_length_select,
	output logic [5:0] cell_bytes,
	output logic [1:0] sram_size,
	output logic [8:0] lookup_capacity_kb
);
	// contents undefined after reset; software fills them
	logic [7:0] txbuf [`CSH_TXBUF_BYTES]; // R01 R21
	logic [7:0] mcmap [`CSH_MCMAP_BYTES]; // R06
	logic [15:0] cfg_r;
	logic [2:0] ahi_r;
	logic [7:0] acc_r;
	logic [15:0] xd_r;
	logic ack_r;
	logic [7:0] rdata_r;
	logic [8:0] xa;
	logic x_done;
	logic x_start;
	logic [1:0] x_we;
	logic dwr;
	logic in_tx;
	logic in_mc;
	logic [5:0] tx_idx;
	logic [5:0] xt_idx;
	logic [4:0] xm_idx;
	logic [15:0] xrd;
	csh_pkg::csh_region_type rgn;

	assign dwr = bus.up_req && bus.up_wr;
	assign in_tx = bus.up_addr >= `CSH_TXBUF_BASE && bus.up_addr <= `CSH_TXBUF_LAST;
	assign in_mc = bus.up_addr[7:5] == 3'(`CSH_MCMAP_BASE >> 5);
	assign tx_idx = 6'(bus.up_addr - `CSH_TXBUF_BASE);
	assign xa = {ahi_r, acc_r[4:0], 1'b0};
	assign x_we = acc_r[6:5];
	assign xt_idx = xa[5:0];
	assign xm_idx = xa[4:0];
	assign x_start = dwr && bus.up_addr == `CSH_EXT_ACC && bus.up_wdata[`CSH_ACC_START]
		&& !acc_r[`CSH_ACC_START];

	// ----------------------------------------
	// extended space decode
	// ----------------------------------------
	always_comb begin
		if (xa <= `CSH_X_TXCOPY_LAST) begin
			rgn = csh_pkg::XR_TXCOPY;
		end else if (xa >= `CSH_X_MCCOPY_BASE && xa <= `CSH_X_MCCOPY_LAST) begin
			rgn = csh_pkg::XR_MCCOPY;
		end else if (xa >= `CSH_X_SDRAM_BASE) begin
			rgn = csh_pkg::XR_SDRAM; // R19
		end else if (xa >= `CSH_X_UTOPIA_BASE) begin
			rgn = csh_pkg::XR_UTOPIA; // R19
		end else if (xa >= `CSH_X_MAIN_BASE) begin
			rgn = csh_pkg::XR_MAIN; // R19
		end else begin
			rgn = csh_pkg::XR_NONE;
		end
	end

	always_comb begin
		case (rgn)
			csh_pkg::XR_TXCOPY: xrd = {txbuf[xt_idx], txbuf[xt_idx | 6'h01]}; // R02
			csh_pkg::XR_MCCOPY: xrd = {mcmap[xm_idx | 5'h01], mcmap[xm_idx]}; // R07
			csh_pkg::XR_MAIN: xrd = (xa == `CSH_X_MAIN_CFG) ? {cfg_r[15:8], 8'h00} : 16'h0000; // R18
			default: xrd = 16'h0000;
		endcase
	end

	csh_ext_timer #(.LAT(EXT_LAT)) u_timer (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(x_start),
		.done(x_done)
	);

	// ----------------------------------------
	// extended access registers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ahi_r <= 3'h0;
		end else if (dwr && bus.up_addr == `CSH_EXT_AHI && !acc_r[`CSH_ACC_START]) begin
			ahi_r <= bus.up_wdata[7:5];
		end
	end

	// address and enables are frozen while an access runs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_r <= 8'h00;
		end else if (x_start) begin
			acc_r <= bus.up_wdata; // R20
		end else if (x_done) begin
			acc_r[`CSH_ACC_START] <= 1'b0; // R20
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xd_r <= 16'h0000;
		end else if (x_done && x_we == 2'b00) begin
			xd_r <= xrd;
		end else if (dwr && bus.up_addr == `CSH_EXT_DHI) begin
			xd_r[15:8] <= bus.up_wdata;
		end else if (dwr && bus.up_addr == `CSH_EXT_DLO) begin
			xd_r[7:0] <= bus.up_wdata;
		end
	end

	// ----------------------------------------
	// shared storage, both paths; setup word written by extended path only
	// ----------------------------------------
	always_ff @(posedge hclk) begin
		if (x_done && rgn == csh_pkg::XR_TXCOPY) begin
			if (x_we[1]) begin
				txbuf[xt_idx] <= xd_r[15:8]; // R02
			end
			if (x_we[0]) begin
				txbuf[xt_idx | 6'h01] <= xd_r[7:0]; // R02
			end
		end
		if (dwr && in_tx) begin
			txbuf[tx_idx] <= bus.up_wdata; // R01 R03
		end
	end

	always_ff @(posedge hclk) begin
		if (x_done && rgn == csh_pkg::XR_MCCOPY) begin
			if (x_we[1]) begin
				mcmap[xm_idx | 5'h01] <= xd_r[15:8]; // R07
			end
			if (x_we[0]) begin
				mcmap[xm_idx] <= xd_r[7:0]; // R06 R07
			end
		end
		if (dwr && in_mc) begin
			mcmap[bus.up_addr[4:0]] <= bus.up_wdata; // R06
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_r <= `CSH_CFG_RESET; // R14 R16
		end else if (x_done && x_we[1] && xa == `CSH_X_MAIN_CFG) begin
			cfg_r[15:8] <= xd_r[15:8]; // R18
		end
	end

	// ----------------------------------------
	// byte bus answer
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ack_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			ack_r <= bus.up_req;
			if (bus.up_req && !bus.up_wr) begin
				if (in_tx) begin
					rdata_r <= txbuf[tx_idx];
				end else if (in_mc) begin
					rdata_r <= mcmap[bus.up_addr[4:0]];
				end else if (bus.up_addr == `CSH_EXT_AHI) begin
					rdata_r <= {ahi_r, 5'h00};
				end else if (bus.up_addr == `CSH_EXT_ACC) begin
					rdata_r <= acc_r;
				end else if (bus.up_addr == `CSH_EXT_DHI) begin
					rdata_r <= xd_r[15:8];
				end else if (bus.up_addr == `CSH_EXT_DLO) begin
					rdata_r <= xd_r[7:0];
				end else begin
					rdata_r <= 8'h00;
				end
			end
		end
	end

	assign bus.up_ack = ack_r;
	assign bus.up_rdata = rdata_r;

	// ----------------------------------------
	// block-side views
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_rd_byte <= 8'h00;
			to_phy0_queue <= 1'b0;
			to_ctrl_rx <= 1'b0;
		end else begin
			tx_rd_byte <= txbuf[tx_rd_idx];
			to_phy0_queue <= mc_valid && !mc_is_ctrl && mcmap[mc_net[7:3]][mc_net[2:0]]; // R04
			to_ctrl_rx <= mc_valid && mc_is_ctrl && mcmap[mc_net[7:3]][mc_net[2:0]]; // R05
		end
	end

	// oe high means driving; idle data floats unless forced on; ATM mode drives start-of-cell unless shared slave
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			utx_soc_oe <= 1'b0;
			utx_data_oe <= 1'b0;
		end else if (cfg_r[`CSH_CFG_FLOAT]) begin
			utx_soc_oe <= 1'b1; // R12
			utx_data_oe <= 1'b1; // R12
		end else if (!cfg_r[`CSH_CFG_LAYER]) begin
			utx_soc_oe <= utx_active; // R11
			utx_data_oe <= utx_active; // R11
		end else begin
			utx_soc_oe <= !(shared_bus && slave_role); // R08 R09 R10
			utx_data_oe <= utx_active; // R08 R09 R10
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lookup_sram_select_zero <= 1'b0;
			lookup_sram_select_one <= 1'b0;
		end else begin
			lookup_sram_select_zero <= lut_req && !(two_srams && lut_bank); // R15
			lookup_sram_select_one <= lut_req && two_srams && lut_bank; // R15
		end
	end

	assign transmit_float_control = cfg_r[`CSH_CFG_FLOAT];
	assign queue0_only = cfg_r[`CSH_CFG_BYPASS]; // R13
	assign sdram_enable = !cfg_r[`CSH_CFG_BYPASS]; // R13
	assign atm_layer_mode = cfg_r[`CSH_CFG_LAYER]; // R14
	assign two_srams = cfg_r[`CSH_CFG_SRAMQ];
	assign cell_length_select = cfg_r[`CSH_CFG_CELL];
	assign cell_bytes = cfg_r[`CSH_CFG_CELL] ? `CSH_CELL_SHORT : `CSH_CELL_LONG; // R16
	assign sram_size = cfg_r[`CSH_CFG_SIZE_LO +: 2];
	assign lookup_capacity_kb = `CSH_LUT_MIN_KB << sram_size; // R17
endmodule : csh_dev

//--- csh_ext_timer.sv
// fixed latency timer for one extended memory access
// assumes start is a one-cycle pulse while not busy
`timescale 1ns/100ps
module csh_ext_timer #(
	parameter int LAT = 4
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// control
	input wire logic start,
	output logic done
);
	logic [7:0] cnt_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 8'h00;
		end else if (start) begin
			cnt_r <= 8'(LAT);
		end else if (cnt_r != 8'h00) begin
			cnt_r <= cnt_r - 8'h01;
		end
	end

	assign done = (cnt_r == 8'h01);
endmodule : csh_ext_timer

//--- csh_host.sv
// controller end: AHB-Lite registers turned into byte bus sequences
// assumes a single AHB-Lite master; hreadyout is the bus hready
`timescale 1ns/100ps
`include "csh_map.svh"
module csh_host (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic [31:0] haddr,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// byte register bus
	csh_upbus_if.host bus
);
	logic wr_pend_r;
	logic [7:0] a_r;
	logic [31:0] cmd_r;
	logic [1:0] policy_r;
	logic [15:0] rword_r;
	logic [2:0] step_r;
	logic [2:0] step_nxt;
	logic busy;
	logic cmd_go;
	logic is_ext;
	logic is_wr;
	logic [15:0] wdat;
	logic [8:0] xa;
	csh_pkg::csh_host_state_type st_r;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign busy = (st_r != csh_pkg::HS_IDLE);
	assign is_ext = cmd_r[`CSH_CMD_EXT];
	assign is_wr = cmd_r[`CSH_CMD_WR];
	assign xa = cmd_r[24:16];
	assign cmd_go = wr_pend_r && (a_r == `CSH_AHB_CMD) && !busy;

	// ----------------------------------------
	// AHB-Lite slave side
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			a_r <= 8'h00;
		end else if (hready) begin
			wr_pend_r <= hsel && htrans[1] && hwrite;
			if (hsel && htrans[1]) begin
				a_r <= haddr[7:0];
			end
		end
	end

	// mux of registered state so a read right after a write sees it
	always_comb begin
		case (a_r)
			`CSH_AHB_CMD: hrdata = cmd_r;
			`CSH_AHB_STATUS: hrdata = {rword_r, 15'h0000, busy};
			`CSH_AHB_POLICY: hrdata = {30'h0, policy_r};
			default: hrdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_r <= 32'h0000_0000;
		end else if (cmd_go) begin
			cmd_r <= hwdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			policy_r <= 2'b00;
		end else if (wr_pend_r && a_r == `CSH_AHB_POLICY) begin
			policy_r <= hwdata[1:0];
		end
	end

	// ----------------------------------------
	// setup word guard
	// ----------------------------------------
	always_comb begin
		wdat = cmd_r[15:0];
		if (is_ext && is_wr && xa == `CSH_X_MAIN_CFG) begin
			wdat[7:0] = 8'h00; // R18
			wdat[`CSH_CFG_RSV] = 1'b0; // R18
			if (policy_r[0]) begin
				wdat[`CSH_CFG_FLOAT] = 1'b0; // R08 R11
			end
			if (policy_r[1]) begin
				wdat[`CSH_CFG_SRAMQ] = 1'b1; // R15
			end
		end
	end

	// ----------------------------------------
	// byte bus sequencer
	// ----------------------------------------
	always_comb begin
		bus.up_wr = 1'b1;
		bus.up_addr = cmd_r[23:16];
		bus.up_wdata = wdat[7:0];
		case (step_r)
			3'd0: begin
				bus.up_addr = `CSH_EXT_DHI;
				bus.up_wdata = wdat[15:8];
			end
			3'd1: bus.up_addr = `CSH_EXT_DLO;
			3'd2: begin
				bus.up_addr = `CSH_EXT_AHI;
				bus.up_wdata = {xa[8:6], 5'h00};
			end
			3'd3: begin
				bus.up_addr = `CSH_EXT_ACC;
				bus.up_wdata = {1'b1, is_wr, is_wr, xa[5:1]}; // R20
			end
			3'd4: begin
				bus.up_wr = 1'b0;
				bus.up_addr = `CSH_EXT_ACC;
			end
			3'd5: begin
				bus.up_wr = 1'b0;
				bus.up_addr = `CSH_EXT_DHI;
			end
			3'd6: begin
				bus.up_wr = 1'b0;
				bus.up_addr = `CSH_EXT_DLO;
			end
			default: bus.up_wr = is_wr;
		endcase
	end

	assign bus.up_req = (st_r == csh_pkg::HS_ISSUE);

	always_comb begin
		case (step_r)
			3'd4: step_nxt = bus.up_rdata[`CSH_ACC_START] ? 3'd4 : 3'd5; // R20
			default: step_nxt = step_r + 3'd1;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= csh_pkg::HS_IDLE;
			step_r <= 3'd0;
		end else begin
			case (st_r)
				csh_pkg::HS_IDLE: if (cmd_go) begin
					st_r <= csh_pkg::HS_ISSUE;
					step_r <= hwdata[`CSH_CMD_EXT] ? 3'd0 : 3'd7;
				end
				csh_pkg::HS_ISSUE: st_r <= csh_pkg::HS_WAIT;
				csh_pkg::HS_WAIT: if (bus.up_ack) begin
					if (step_r == 3'd7 || step_r == 3'd6 || (step_nxt == 3'd5 && is_wr)) begin
						st_r <= csh_pkg::HS_IDLE;
					end else begin
						st_r <= csh_pkg::HS_ISSUE;
						step_r <= step_nxt;
					end
				end
				default: st_r <= csh_pkg::HS_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rword_r <= 16'h0000;
		end else if (st_r == csh_pkg::HS_WAIT && bus.up_ack) begin
			if (step_r == 3'd5) begin
				rword_r[15:8] <= bus.up_rdata;
			end else if (step_r == 3'd6 || (step_r == 3'd7 && !is_wr)) begin
				rword_r[7:0] <= bus.up_rdata;
			end
		end
	end
endmodule : csh_host

//--- csh_link_properties.sv
// concurrent checks on the byte register bus joining controller and device
// assumes one clock, strobes are one-cycle pulses, start bit at 0x34 bit 7
`timescale 1ns/100ps
`include "csh_map.svh"
module csh_link_properties #(
	parameter int EXT_LAT = `CSH_EXT_LAT
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// byte bus
	input wire logic up_req,
	input wire logic up_wr,
	input wire logic [7:0] up_addr,
	input wire logic [7:0] up_wdata,
	input wire logic up_ack,
	input wire logic [7:0] up_rdata
);
	logic last_wr_r;
	logic [7:0] last_addr_r;
	logic [7:0] age_r;
	logic armed_r;
	wire logic start_wr = up_req && up_wr && up_addr == `CSH_EXT_ACC && up_wdata[`CSH_ACC_START];
	wire logic poll_ack = up_ack && !last_wr_r && last_addr_r == `CSH_EXT_ACC;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_wr_r <= 1'b0;
			last_addr_r <= 8'h00;
		end else if (up_req) begin
			last_wr_r <= up_wr;
			last_addr_r <= up_addr;
		end
	end

	// age of the latest start, saturating so old starts stay harmless
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			age_r <= 8'h00;
			armed_r <= 1'b0;
		end else if (start_wr) begin
			age_r <= 8'h00;
			armed_r <= 1'b1;
		end else if (age_r != 8'hff) begin
			age_r <= age_r + 8'h01;
		end
	end

	property p_ack_next;
		@(posedge hclk) disable iff (!hresetn) up_req |=> up_ack;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
	property p_ack_cause;
		@(posedge hclk) disable iff (!hresetn) up_ack |-> $past(up_req);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_req_gap;
		@(posedge hclk) disable iff (!hresetn) up_req |=> !up_req;
	endproperty
	a_req_gap: assert property (p_req_gap) else $error("requests too close");
	property p_ack_pulse;
		@(posedge hclk) disable iff (!hresetn) up_ack |-> !up_req ##1 !up_ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single pulse");
	property p_rdata_hold;
		@(posedge hclk) disable iff (!hresetn) (!up_ack || last_wr_r) |-> $stable(up_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read byte moved without read");
	property p_busy_early;
		@(posedge hclk) disable iff (!hresetn) poll_ack && armed_r && int'(age_r) <= EXT_LAT - 2 |-> up_rdata[7];
	endproperty
	a_busy_early: assert property (p_busy_early) else $error("start bit cleared too soon");
	property p_done_late;
		@(posedge hclk) disable iff (!hresetn) poll_ack && armed_r && int'(age_r) >= EXT_LAT + 2 |-> !up_rdata[7];
	endproperty
	a_done_late: assert property (p_done_late) else $error("start bit still set");
	property p_poll_ends;
		@(posedge hclk) disable iff (!hresetn) start_wr |-> ##[2:60] (poll_ack && !up_rdata[7]);
	endproperty
	a_poll_ends: assert property (p_poll_ends) else $error("extended access never finished");
endmodule : csh_link_properties

//--- csh_map.svh
// constants of the cell switch host configuration bank: offsets, fields, resets
// assumes an 8-bit direct register bus and a 9-bit extended word address
// Overview of operation
// R01 - transmit buffer holds 56 bytes, headers first
// R02 - direct and extended transmit copies share storage
// R03 - host loads whole cell before transmit request
// R04 - 256 enable bits route multicast cells port 0
// R05 - enabled multicast control cells go to receive
// R06 - bitmap: sixteen 16-bit words, net 0 lowest
// R07 - direct and extended bitmap share storage
// R08 - shared ATM: float control zero, slave floats
// R09 - shared ATM master floats idle data, parity
// R10 - nonshared ATM floats idle data and parity
// R11 - PHY mode floats all idle; multi-PHY keeps zero
// R12 - float control one drives outputs always
// R13 - bypass: internal memory, queue 0, no SDRAM
// R14 - layer select resets one, one means ATM
// R15 - count bit zero: only SRAM select zero
// R16 - cell format resets one: 53 bytes, else 55
// R17 - size field picks 32K to 256K bytes
// R18 - low byte reads zero; bit 15 kept zero
// R19 - extended space: main, UTOPIA, SDRAM regions
// R20 - start bit begins access, clears when finished
// R21 - host initialises buffer and bitmap after reset
`ifndef CSH_MAP_SVH
`define CSH_MAP_SVH

// ----------------------------------------
// direct register space
// ----------------------------------------
`define CSH_TXBUF_BASE 8'ha0
`define CSH_TXBUF_LAST 8'hd7
`define CSH_TXBUF_BYTES 56
`define CSH_MCMAP_BASE 8'he0
`define CSH_MCMAP_BYTES 32
`define CSH_EXT_AHI 8'h33
`define CSH_EXT_ACC 8'h34
`define CSH_EXT_DHI 8'h36
`define CSH_EXT_DLO 8'h37
`define CSH_ACC_START 7

// ----------------------------------------
// extended word space
// ----------------------------------------
`define CSH_X_TXCOPY_LAST 9'h037
`define CSH_X_MCCOPY_BASE 9'h040
`define CSH_X_MCCOPY_LAST 9'h05f
`define CSH_X_MAIN_BASE 9'h100
`define CSH_X_UTOPIA_BASE 9'h140
`define CSH_X_SDRAM_BASE 9'h180
`define CSH_X_MAIN_CFG 9'h100
`define CSH_EXT_LAT 4

// ----------------------------------------
// main setup word one
// ----------------------------------------
`define CSH_CFG_RESET 16'h1400
`define CSH_CFG_FLOAT 8
`define CSH_CFG_BYPASS 9
`define CSH_CFG_LAYER 10
`define CSH_CFG_SRAMQ 11
`define CSH_CFG_CELL 12
`define CSH_CFG_SIZE_LO 13
`define CSH_CFG_RSV 15
`define CSH_CELL_SHORT 6'd53
`define CSH_CELL_LONG 6'd55
`define CSH_LUT_MIN_KB 9'd32

// ----------------------------------------
// controller registers on AHB-Lite
// ----------------------------------------
`define CSH_AHB_CMD 8'h00
`define CSH_AHB_STATUS 8'h04
`define CSH_AHB_POLICY 8'h08
`define CSH_CMD_EXT 28
`define CSH_CMD_WR 29

`endif

//--- csh_pkg.sv
// types shared by both ends of the configuration bank link
// assumes csh_map.svh supplies the numbers
package csh_pkg;
	typedef enum logic [2:0] {
		XR_TXCOPY, XR_MCCOPY, XR_MAIN, XR_UTOPIA, XR_SDRAM, XR_NONE
	} csh_region_type;
	typedef enum {HS_IDLE, HS_ISSUE, HS_WAIT} csh_host_state_type;
endpackage : csh_pkg

//--- csh_upbus_if.sv
// parallel byte register bus between controller and configuration bank
// assumes one clock; strobes are one-cycle pulses
`timescale 1ns/100ps
interface csh_upbus_if;
	logic up_req;
	logic up_wr;
	logic [7:0] up_addr;
	logic [7:0] up_wdata;
	logic up_ack;
	logic [7:0] up_rdata;
	modport host (output up_req, output up_wr, output up_addr, output up_wdata,
		input up_ack, input up_rdata);
	modport dev (input up_req, input up_wr, input up_addr, input up_wdata,
		output up_ack, output up_rdata);
endinterface : csh_upbus_if

//--- test_cell_switch_host_config_regs.sv
// self-checking bench: AHB-Lite master on the controller, device end behind it
// assumes zero-wait controller registers at 0x00, 0x04, 0x08
`timescale 1ns/100ps
module test_cell_switch_host_config_regs;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, got_v;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, got;
	logic [5:0] tx_rd_idx, cell_bytes;
	logic [7:0] tx_rd_byte, mc_net;
	logic mc_valid, mc_is_ctrl, to_phy0_queue, to_ctrl_rx, utx_active, shared_bus, slave_role;
	logic utx_soc_oe, utx_data_oe, lut_req, lut_bank, sel0, sel1;
	logic float_ctl, sdram_en, q0_only, atm_mode, two_srams, cell_len;
	logic [1:0] sram_size;
	logic [8:0] cap_kb;
	int failures, num_checks;
	logic [31:0] exp_q[$];
	logic [7:0] mem[64];
	logic [15:0] mcw[16];

	csh_upbus_if bus();
	csh_host csh_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .haddr(haddr),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .bus(bus.host));
	csh_dev #(.EXT_LAT(4)) csh_dev_inst (.hclk(hclk), .hresetn(hresetn), .bus(bus.dev),
		.tx_rd_idx(tx_rd_idx), .tx_rd_byte(tx_rd_byte), .mc_valid(mc_valid), .mc_is_ctrl(mc_is_ctrl),
		.mc_net(mc_net), .to_phy0_queue(to_phy0_queue), .to_ctrl_rx(to_ctrl_rx), .utx_active(utx_active),
		.shared_bus(shared_bus), .slave_role(slave_role), .utx_soc_oe(utx_soc_oe), .utx_data_oe(utx_data_oe),
		.lut_req(lut_req), .lut_bank(lut_bank), .lookup_sram_select_zero(sel0), .lookup_sram_select_one(sel1),
		.transmit_float_control(float_ctl), .sdram_enable(sdram_en), .queue0_only(q0_only),
		.atm_layer_mode(atm_mode), .two_srams(two_srams), .cell_length_select(cell_len),
		.cell_bytes(cell_bytes), .sram_size(sram_size), .lookup_capacity_kb(cap_kb));
	csh_link_properties #(.EXT_LAT(4)) csh_link_properties_inst (.hclk(hclk), .hresetn(hresetn),
		.up_req(bus.up_req), .up_wr(bus.up_wr), .up_addr(bus.up_addr), .up_wdata(bus.up_wdata),
		.up_ack(bus.up_ack), .up_rdata(bus.up_rdata));

	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	task automatic conclude;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic pin(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask : pin

	// one AHB single transfer; waits on hready in both phases
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		r = hrdata;
		if (n >= 100) begin
			failures++;
			conclude();
		end
	endtask : xfer

	task automatic op(input logic [31:0] cmd, output logic [31:0] st);
		int n;
		n = 0;
		xfer(1'b1, 8'h00, cmd, st);
		do begin
			xfer(1'b0, 8'h04, 32'h0, st);
			n++;
		end while (st[0] !== 1'b0 && n < 100);
		if (n >= 100) begin
			failures++;
			conclude();
		end
	endtask : op

	task automatic wr(input logic ext, input logic [8:0] a, input logic [15:0] d);
		logic [31:0] st;
		op({2'h0, 1'b1, ext, 3'h0, a, d}, st);
	endtask : wr

	// expectation noted first; the monitor compares when the result shows
	task automatic rd(input logic ext, input logic [8:0] a, input logic [15:0] e);
		logic [31:0] st;
		exp_q.push_back(ext ? {e, 16'h0} : {8'h0, e[7:0], 16'h0});
		op({3'h0, ext, 3'h0, a, 16'h0}, st);
		got <= ext ? {st[31:16], 16'h0} : {8'h0, st[23:16], 16'h0};
		got_v <= 1'b1;
		@(posedge hclk);
		got_v <= 1'b0;
	endtask : rd

	always @(posedge hclk) begin
		if (got_v === 1'b1) begin
			chk(got, exp_q.pop_front());
		end
	end

	initial begin
		#2000000;
		failures++;
		conclude();
	end

	initial begin
		logic [31:0] st;
		logic [15:0] v, e;
		logic c, bv, vl;
		logic [7:0] n;
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, got, got_v} = '0;
		{tx_rd_idx, mc_valid, mc_is_ctrl, mc_net, utx_active, shared_bus, slave_role, lut_req, lut_bank} = '0;
		void'($urandom(43));
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rd(1'b1, 9'h100, 16'h1400);
		chk(32'(cell_bytes), 32'd53);
		chk(32'(cap_kb), 32'd32);
		pin(sdram_en, 1'b1);
		rd(1'b1, 9'h140, 16'h0);
		rd(1'b1, 9'h180, 16'h0);
		xfer(1'b0, 8'h0c, 32'h0, st);
		chk(st, 32'h0);
		pin(hresp, 1'b0);
		for (int k = 0; k < 24; k++) begin
			v = 16'($urandom);
			v[14:13] = k[1:0];
			e = v & 16'h7f00;
			wr(1'b1, 9'h100, v);
			rd(1'b1, 9'h100, e);
			chk(32'(cap_kb), 32'd32 << e[14:13]);
			chk(32'(cell_bytes), e[12] ? 32'd53 : 32'd55);
			pin(sdram_en, !e[9]);
			pin(q0_only, e[9]);
			pin(atm_mode, e[10]);
			pin(float_ctl, e[8]);
			pin(two_srams, e[11]);
			pin(cell_len, e[12]);
			chk(32'(sram_size), 32'(e[14:13]));
			{utx_active, shared_bus, slave_role, lut_req, lut_bank} <= 5'($urandom);
			@(posedge hclk);
			@(negedge hclk);
			pin(utx_soc_oe, e[8] | (e[10] ? !(shared_bus & slave_role) : utx_active));
			pin(utx_data_oe, e[8] | utx_active);
			pin(sel0, lut_req & (!e[11] | !lut_bank));
			pin(sel1, lut_req & e[11] & lut_bank);
		end
		xfer(1'b1, 8'h08, 32'h3, st);
		wr(1'b1, 9'h100, 16'h0100);
		rd(1'b1, 9'h100, 16'h0800);
		xfer(1'b1, 8'h08, 32'h0, st);
		for (int i = 0; i < 56; i++) begin
			mem[i] = 8'($urandom);
			wr(1'b0, 9'h0a0 + 9'(i), {8'h0, mem[i]});
		end
		for (int i = 0; i < 56; i += 2) begin
			rd(1'b1, 9'(i), {mem[i], mem[i + 1]});
		end
		v = 16'($urandom);
		{mem[54], mem[55]} = v;
		wr(1'b1, 9'h036, v);
		rd(1'b0, 9'h0d7, {8'h0, v[7:0]});
		for (int i = 0; i < 56; i += 55) begin
			@(posedge hclk);
			tx_rd_idx <= 6'(i);
			@(posedge hclk);
			@(negedge hclk);
			chk({24'h0, tx_rd_byte}, {24'h0, mem[i]});
		end
		for (int w = 0; w < 16; w++) begin
			mcw[w] = 16'($urandom);
			wr(1'b0, 9'h0e0 + 9'(2 * w), {8'h0, mcw[w][7:0]});
			wr(1'b0, 9'h0e1 + 9'(2 * w), {8'h0, mcw[w][15:8]});
			rd(1'b1, 9'h040 + 9'(2 * w), mcw[w]);
		end
		mcw[15] = 16'($urandom);
		wr(1'b1, 9'h05e, mcw[15]);
		rd(1'b0, 9'h0ff, {8'h0, mcw[15][15:8]});
		for (int i = 0; i < 48; i++) begin
			n = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
			{c, vl} = 2'($urandom);
			bv = mcw[n[7:4]][n[3:0]] & (vl | i < 2);
			@(posedge hclk);
			mc_net <= n;
			mc_is_ctrl <= c;
			mc_valid <= vl | i < 2;
			@(posedge hclk);
			@(negedge hclk);
			pin(to_phy0_queue, !c & bv);
			pin(to_ctrl_rx, c & bv);
		end
		conclude();
	end
endmodule : test_cell_switch_host_config_regs
